// ==== byte_fifo.sv ====
// Synchronous FIFO with valid/ready handshakes on both sides.
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic  clk_sys_in,
  input  wire logic  sys_rst_in,
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  // Full and empty come straight from the occupancy count.
  wire do_wr = fill.valid & fill.ready;
  wire do_rd = drain.valid & drain.ready;
  assign fill.ready  = (count != (AW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rd_ptr];

  // Pointers and count advance on each accepted transfer.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Storage is written without reset.
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) mem[wr_ptr] <= fill.data;
  end
endmodule

// ==== byte_stream_if.sv ====
// Valid/ready byte stream between the port logic and its buffer.
`timescale 1ns/100ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== pin_sync.sv ====
// Two-stage synchroniser for pins from outside the system clock.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_sys_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== prog_port_pkg.sv ====
// Constants and types shared by the serial programming port.
package prog_port_pkg;

  // ----------------------------------------------------------------
  // Instruction codes and capture pattern
  // ----------------------------------------------------------------
  localparam int          IR_W              = 4;
  localparam logic [3:0]  DEVICE_RESET_INSTR = 4'hc;
  localparam logic [3:0]  PROGRAM_KEY_INSTR  = 4'h4;
  localparam logic [3:0]  PROGRAM_CMD_INSTR  = 4'h5;
  localparam logic [3:0]  PAGE_LOAD_INSTR    = 4'h6;
  localparam logic [3:0]  PAGE_READ_INSTR    = 4'h7;
  localparam logic [3:0]  BYPASS_INSTR       = 4'hf;
  localparam logic [3:0]  IR_CAPTURE         = 4'h1;

  // ----------------------------------------------------------------
  // Data register widths and reset values
  // ----------------------------------------------------------------
  localparam int           KEY_W      = 16;
  localparam logic [15:0]  KEY_VALUE  = 16'ha370;
  localparam logic [15:0]  KEY_RESET  = 16'h0000;
  localparam int           CMD_W      = 15;
  localparam logic [14:0]  CMD_RESET  = 15'h0000;
  localparam int           BYTE_W     = 8;
  localparam logic [2:0]   LAST_BIT   = 3'h7;
  localparam int           FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Reset time-out after the reset chain is released
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          TO_SHORT_NS   = 4000;
  localparam int          TO_LONG_NS    = 65000;
  localparam logic [11:0] TO_SHORT_CYC  =
    12'((TO_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] TO_LONG_CYC   =
    12'((TO_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Test access port controller states.
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } tap_state_t;

endpackage

// ==== prog_port_top.sv ====
// Serial test-port programming logic: instruction decode and data chains.
`timescale 1ns/100ps
module prog_port_top (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        tck_in,
  input  wire logic        tms_in,
  input  wire logic        tdi_in,
  output logic             tdo_out,
  output logic             tdo_oe_out,
  input  wire logic        clk_opt_long_in,
  output logic             dev_reset_out,
  output logic             prog_mode_out,
  output logic [14:0]      cmd_word_out,
  input  wire logic [14:0] cmd_result_in,
  output logic             exec_pulse_out,
  output logic [7:0]       page_data_out,
  output logic             page_valid_out,
  input  wire logic        page_ready_in,
  output logic             page_load_ready_out,
  output logic             page_rd_req_out,
  input  wire logic [7:0]  page_rd_data_in
);

  // ----------------------------------------------------------------
  // Pin sampling and clock edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins;
  logic       tck_q;

  pin_sync #(.W(3)) u_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({tck_in, tms_in, tdi_in}),
    .sync_out   (pins)
  );

  // The delayed test clock gives one-cycle edge strobes.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) tck_q <= 1'b0;
    else            tck_q <= pins[2];
  end

  wire tck_rise = pins[2] & ~tck_q;
  wire tck_fall = ~pins[2] & tck_q;
  wire tms_s    = pins[1];
  wire tdi_s    = pins[0];

  // ----------------------------------------------------------------
  // Test access port controller
  // ----------------------------------------------------------------
  prog_port_pkg::tap_state_t state;
  prog_port_pkg::tap_state_t next_state;

  // Standard sixteen-state walk steered by the mode pin.
  always_comb begin
    case (state)
      prog_port_pkg::TLR:    next_state = tms_s ? prog_port_pkg::TLR
                                                : prog_port_pkg::RTI;
      prog_port_pkg::RTI:    next_state = tms_s ? prog_port_pkg::SEL_DR
                                                : prog_port_pkg::RTI;
      prog_port_pkg::SEL_DR: next_state = tms_s ? prog_port_pkg::SEL_IR
                                                : prog_port_pkg::CAP_DR;
      prog_port_pkg::CAP_DR: next_state = tms_s ? prog_port_pkg::EX1_DR
                                                : prog_port_pkg::SH_DR;
      prog_port_pkg::SH_DR:  next_state = tms_s ? prog_port_pkg::EX1_DR
                                                : prog_port_pkg::SH_DR;
      prog_port_pkg::EX1_DR: next_state = tms_s ? prog_port_pkg::UP_DR
                                                : prog_port_pkg::PA_DR;
      prog_port_pkg::PA_DR:  next_state = tms_s ? prog_port_pkg::EX2_DR
                                                : prog_port_pkg::PA_DR;
      prog_port_pkg::EX2_DR: next_state = tms_s ? prog_port_pkg::UP_DR
                                                : prog_port_pkg::SH_DR;
      prog_port_pkg::SEL_IR: next_state = tms_s ? prog_port_pkg::TLR
                                                : prog_port_pkg::CAP_IR;
      prog_port_pkg::CAP_IR: next_state = tms_s ? prog_port_pkg::EX1_IR
                                                : prog_port_pkg::SH_IR;
      prog_port_pkg::SH_IR:  next_state = tms_s ? prog_port_pkg::EX1_IR
                                                : prog_port_pkg::SH_IR;
      prog_port_pkg::EX1_IR: next_state = tms_s ? prog_port_pkg::UP_IR
                                                : prog_port_pkg::PA_IR;
      prog_port_pkg::PA_IR:  next_state = tms_s ? prog_port_pkg::EX2_IR
                                                : prog_port_pkg::PA_IR;
      prog_port_pkg::EX2_IR: next_state = tms_s ? prog_port_pkg::UP_IR
                                                : prog_port_pkg::SH_IR;
      prog_port_pkg::UP_DR,
      prog_port_pkg::UP_IR:  next_state = tms_s ? prog_port_pkg::SEL_DR
                                                : prog_port_pkg::RTI;
      default:               next_state = prog_port_pkg::TLR;
    endcase
  end

  // The controller moves only on a rising test clock edge.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in)    state <= prog_port_pkg::TLR;
    else if (tck_rise) state <= next_state;
  end

  // ----------------------------------------------------------------
  // Instruction register and decode
  // ----------------------------------------------------------------
  logic [3:0] ir;
  logic [3:0] ir_sr;

  // Four-bit instruction shifted in least significant bit first.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ir    <= prog_port_pkg::BYPASS_INSTR;
      ir_sr <= 4'h0;
    end else if (tck_rise) begin
      case (state)
        prog_port_pkg::TLR:    ir    <= prog_port_pkg::BYPASS_INSTR;
        prog_port_pkg::CAP_IR: ir_sr <= prog_port_pkg::IR_CAPTURE;
        prog_port_pkg::SH_IR:  ir_sr <= {tdi_s, ir_sr[3:1]};
        prog_port_pkg::UP_IR:  ir    <= ir_sr;
        default: ;
      endcase
    end
  end

  // Chain selection and per-state test clock strobes.
  logic prog_mode;
  wire sel_rst    = (ir == prog_port_pkg::DEVICE_RESET_INSTR);
  wire sel_key    = (ir == prog_port_pkg::PROGRAM_KEY_INSTR);
  wire prog_cmd   = (ir == prog_port_pkg::PROGRAM_CMD_INSTR)
                    & prog_mode;
  wire prog_load  = (ir == prog_port_pkg::PAGE_LOAD_INSTR)
                    & prog_mode;
  wire prog_read  = (ir == prog_port_pkg::PAGE_READ_INSTR)
                    & prog_mode;
  wire tick_cap   = tck_rise & (state == prog_port_pkg::CAP_DR);
  wire tick_shift = tck_rise & (state == prog_port_pkg::SH_DR);
  wire tick_upd   = tck_rise & (state == prog_port_pkg::UP_DR);
  wire tick_idle  = tck_rise & (state == prog_port_pkg::RTI);

  // ----------------------------------------------------------------
  // Reset chain, bypass bit and reset time-out
  // ----------------------------------------------------------------
  logic        rst_chain;
  logic        rst_chain_q;
  logic        bypass;
  logic [11:0] to_cnt;

  // The reset chain is untouched by the controller's own reset state.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rst_chain <= 1'b0;
      bypass    <= 1'b0;
    end else begin
      if (tick_shift && sel_rst) rst_chain <= tdi_s;
      if (tick_cap)              bypass    <= 1'b0;
      else if (tick_shift)       bypass    <= tdi_s;
    end
  end

  // Releasing the chain starts the fuse-selected hold-off.
  wire        chain_release = rst_chain_q & ~rst_chain;
  wire [11:0] to_len        = clk_opt_long_in ? prog_port_pkg::TO_LONG_CYC
                                              : prog_port_pkg::TO_SHORT_CYC;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rst_chain_q <= 1'b0;
      to_cnt      <= 12'h000;
    end else begin
      rst_chain_q <= rst_chain;
      if (chain_release)       to_cnt <= to_len;
      else if (to_cnt != '0)   to_cnt <= to_cnt - 12'h001;
    end
  end

  // Unlatched: the chain bit reaches the reset output with no delay.
  // The release strobe bridges the cycle before the counter is loaded.
  assign dev_reset_out = rst_chain | chain_release
                         | (to_cnt != 12'h000);

  // ----------------------------------------------------------------
  // Enable key
  // ----------------------------------------------------------------
  logic [15:0] key_sr;

  // A wrong key on update leaves programming mode again.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      key_sr    <= prog_port_pkg::KEY_RESET;
      prog_mode <= 1'b0;
    end else begin
      if (tick_shift && sel_key) key_sr <= {tdi_s, key_sr[15:1]};
      if (tick_upd && sel_key)
        prog_mode <= (key_sr == prog_port_pkg::KEY_VALUE);
    end
  end

  assign prog_mode_out = prog_mode;

  // ----------------------------------------------------------------
  // Command register and execution clock
  // ----------------------------------------------------------------
  logic [14:0] cmd_sr;
  logic        cmd_armed;

  // The applied word drives the memory inputs unchanged; the memory
  // side decodes erase, write, read, latch and poll sequences.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cmd_sr       <= prog_port_pkg::CMD_RESET;
      cmd_word_out <= prog_port_pkg::CMD_RESET;
      cmd_armed    <= 1'b0;
    end else begin
      if (tick_cap && prog_cmd)
        cmd_sr <= cmd_result_in;
      else if (tick_shift && prog_cmd)
        cmd_sr <= {tdi_s, cmd_sr[14:1]};
      if (tick_upd && prog_cmd) begin
        cmd_word_out <= cmd_sr;
        cmd_armed    <= 1'b1;
      end else if (!prog_mode) begin
        cmd_armed    <= 1'b0;
      end
    end
  end

  // One execution pulse per test clock spent in Run-Test/Idle while the command instruction is selected and a command is applied.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) exec_pulse_out <= 1'b0;
    else exec_pulse_out <= tick_idle & prog_cmd & cmd_armed;
  end

  // ----------------------------------------------------------------
  // Page load and page read chains
  // ----------------------------------------------------------------
  byte_stream_if load_if ();
  byte_stream_if drain_if ();

  logic [2:0] bit_cnt;
  logic [7:0] pl_sr;
  logic [7:0] pr_sr;
  logic [7:0] pr_hold;
  logic       rd_pend;
  logic       push_valid;
  logic [7:0] push_data;

  wire byte_done = (bit_cnt == prog_port_pkg::LAST_BIT);

  // Bit position within the current byte of either page chain.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in)                           bit_cnt <= 3'h0;
    else if (tick_cap)                        bit_cnt <= 3'h0;
    else if (tick_shift && (prog_load || prog_read))
      bit_cnt <= bit_cnt + 3'h1;
  end

  // Each completed byte goes to the buffer while shifting; a full
  // buffer refuses the byte, which the ready output lets a host see.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pl_sr      <= 8'h00;
      push_valid <= 1'b0;
      push_data  <= 8'h00;
    end else begin
      push_valid <= tick_shift & prog_load & byte_done
                    & load_if.ready;
      if (tick_shift && prog_load) begin
        pl_sr     <= {tdi_s, pl_sr[7:1]};
        push_data <= {tdi_s, pl_sr[7:1]};
      end
    end
  end

  assign load_if.valid = push_valid;
  assign load_if.data  = push_data;

  // Capture only prefetches; the first byte out is the filler byte.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pr_sr           <= 8'h00;
      pr_hold         <= 8'h00;
      rd_pend         <= 1'b0;
      page_rd_req_out <= 1'b0;
    end else begin
      page_rd_req_out <= (tick_cap & prog_read)
                         | (tick_shift & prog_read & byte_done);
      rd_pend         <= page_rd_req_out;
      if (rd_pend) pr_hold <= page_rd_data_in;
      if (tick_cap && prog_read)
        pr_sr <= 8'h00;
      else if (tick_shift && prog_read)
        pr_sr <= byte_done ? pr_hold : {1'b0, pr_sr[7:1]};
    end
  end

  byte_fifo #(
    .WIDTH (prog_port_pkg::BYTE_W),
    .DEPTH (prog_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .fill       (load_if),
    .drain      (drain_if)
  );

  assign page_data_out       = drain_if.data;
  assign page_valid_out      = drain_if.valid;
  assign drain_if.ready      = page_ready_in;
  assign page_load_ready_out = load_if.ready;

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  wire shifting = (state == prog_port_pkg::SH_DR)
                  | (state == prog_port_pkg::SH_IR);
  wire tdo_bit  = (state == prog_port_pkg::SH_IR) ? ir_sr[0]
                : sel_rst   ? rst_chain
                : sel_key   ? key_sr[0]
                : prog_cmd  ? cmd_sr[0]
                : prog_read ? pr_sr[0]
                : prog_load ? pl_sr[0]
                : bypass;

  // Output changes on the falling test clock edge.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= tdo_bit;
      tdo_oe_out <= shifting;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ir_update: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tck_rise && state == prog_port_pkg::UP_IR) |=> ir == $past(ir_sr))
    else $error("Instruction not updated from shift register.");

  a_reset_chain_out: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    rst_chain |-> dev_reset_out)
    else $error("Reset chain set but device reset low.");

  a_timeout_hold: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(rst_chain) |-> dev_reset_out [*8])
    else $error("Device reset ended without time-out.");

  a_key_accept: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_upd && sel_key && key_sr == prog_port_pkg::KEY_VALUE)
      |=> prog_mode)
    else $error("Matching key did not enter programming mode.");

  a_key_reject: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_upd && sel_key && key_sr != prog_port_pkg::KEY_VALUE)
      |=> !prog_mode)
    else $error("Wrong key entered programming mode.");

  a_capture_result: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_cap && prog_cmd) |=> cmd_sr == $past(cmd_result_in))
    else $error("Capture did not load command result.");

  a_cmd_apply: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_upd && prog_cmd) |=> cmd_word_out == $past(cmd_sr))
    else $error("Update did not apply shifted command.");

  a_exec_pulse: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_idle && prog_cmd && cmd_armed) |=> exec_pulse_out ##1
      !exec_pulse_out)
    else $error("Idle clock did not give one execution pulse.");

  a_exec_gated: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !prog_mode |=> !exec_pulse_out)
    else $error("Execution pulse outside programming mode.");

  a_page_push: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick_shift && prog_load && byte_done && load_if.ready)
      |=> load_if.valid && load_if.data == {$past(tdi_s), $past(pl_sr[7:1])})
    else $error("Completed page byte not pushed.");

endmodule

// ==== prog_programmer.sv ====
// Behavioural test-port programmer that drives the link pins.
`timescale 1ns/100ps
module prog_programmer (
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in
);
  // The test clock stands low outside frames.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One test clock; data out is taken just before the rising edge.
  task automatic step(input logic ms, input logic di, output logic dq);
    tms_out = ms;
    tdi_out = di;
    #80;
    dq = tdo_in;
    tck_out = 1'b1;
    #80;
    tck_out = 1'b0;
  endtask
  // Scan n bits through IR or DR, starting and ending at rest in idle.
  task automatic scan(input logic ir, input int n, input logic [143:0] din,
                      output logic [143:0] dout);
    logic d;
    dout = '0;
    step(1'b1, ~tdi_out, d);
    if (ir) begin
      step(1'b1, ~tdi_out, d);
    end
    step(1'b0, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
  endtask
endmodule

// ==== tb_jtag_programming_port.sv ====
// Self-checking bench for the serial programming port.
`timescale 1ns/100ps
module tb_jtag_programming_port;
  logic         clk_sys_in, sys_rst_in, tck, tms, tdi, tdo, opt_long;
  logic         dev_reset, prog_mode, exec_pulse, page_valid, page_ready;
  logic         load_ready, rd_req, oe;
  logic [14:0]  cmd_word, cmd_result, c;
  logic [7:0]   page_data, rd_data;
  logic [143:0] dout, v;
  logic [31:0]  lfsr_state = 32'h5890;
  logic [7:0]   exp_q[$];
  logic [7:0]   rd_q[$];
  int           mismatches = 0;
  int           num_checks = 0;
  int           execs = 0;
  int           oe_cnt = 0;
  int           polls = 0;
  // Memory command words, low byte filled at random for loads; leading
  // words already set by the previous command are left out.
  localparam logic [14:0] CMDS [16] = '{15'h2380, 15'h3180, 15'h3380,
    15'h3380, 15'h2310, 15'h0700, 15'h0300, 15'h1300, 15'h1700, 15'h3700,
    15'h7700, 15'h3500, 15'h2302, 15'h3600, 15'h2311, 15'h2303};
  function automatic logic [31:0] next_rand();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^
                  lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction
  // Clock cycles the device must stay in reset after the chain clears.
  function automatic int hold_cycles(input logic long_opt);
    return long_opt ? int'(prog_port_pkg::TO_LONG_CYC)
                    : int'(prog_port_pkg::TO_SHORT_CYC);
  endfunction
  task automatic check(input logic [143:0] seen, input logic [143:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic set_ir(input logic [3:0] code);
    u_prog_programmer.scan(1'b1, 4, 144'(code), dout);
    check(dout[3:0], prog_port_pkg::IR_CAPTURE);
  endtask
  task automatic dr(input int n, input logic [143:0] din);
    u_prog_programmer.scan(1'b0, n, din, dout);
  endtask
  task automatic key(input logic [15:0] k);
    set_ir(prog_port_pkg::PROGRAM_KEY_INSTR);
    oe_cnt = 0;
    dr(16, 144'(k));
    check(oe_cnt, 16 * 8);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Clock, hang guard, exec pulse counter and page byte source.
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    mismatches++;
    wrap_up();
  end
  always @(posedge clk_sys_in) begin
    if (exec_pulse === 1'b1) execs++;
    if (oe === 1'b1) oe_cnt++;
    if (rd_req === 1'b1 && rd_q.size() > 0) rd_data <= #1 rd_q.pop_front();
    else rd_data <= #1 ~rd_data;
  end
  // A released data out pin reads as pulled high.
  prog_programmer u_prog_programmer (.tck_out(tck), .tms_out(tms),
    .tdi_out(tdi), .tdo_in(oe ? tdo : 1'b1));
  prog_port_top u_prog_port_top (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(oe), .clk_opt_long_in(opt_long),
    .dev_reset_out(dev_reset), .prog_mode_out(prog_mode),
    .cmd_word_out(cmd_word), .cmd_result_in(cmd_result),
    .exec_pulse_out(exec_pulse), .page_data_out(page_data),
    .page_valid_out(page_valid), .page_ready_in(page_ready),
    .page_load_ready_out(load_ready), .page_rd_req_out(rd_req),
    .page_rd_data_in(rd_data));
  // Main sequence: reset, refusal, reset chain, key, commands, pages.
  initial begin
    sys_rst_in = 1'b1;
    opt_long = 1'b0;
    cmd_result = '0;
    page_ready = 1'b0;
    rd_data = '0;
    wait_clk(8);
    sys_rst_in = 1'b0;
    wait_clk(4);
    check(prog_mode, 1'b0);
    check(cmd_word, 15'h0000);
    // Leave Test-Logic-Reset for Run-Test/Idle before the first scan.
    u_prog_programmer.step(1'b0, 1'b0, v[0]);
    set_ir(prog_port_pkg::PROGRAM_CMD_INSTR);
    dr(15, 144'h2380);
    check(cmd_word, 15'h0000);
    set_ir(prog_port_pkg::DEVICE_RESET_INSTR);
    // Short and long hold-off after the reset chain is released.
    for (int m = 0; m < 2; m++) begin
      opt_long = m[0];
      dr(1, 144'h1);
      check(dev_reset, 1'b1);
      dr(1, 144'h0);
      wait_clk(hold_cycles(opt_long) - 80);
      check(dev_reset, 1'b1);
      wait_clk(100);
      check(dev_reset, 1'b0);
    end
    dr(1, 144'h1);
    c = 15'(next_rand());
    key(16'(c) == prog_port_pkg::KEY_VALUE ? 16'h0000 : 16'(c));
    check(prog_mode, 1'b0);
    key(prog_port_pkg::KEY_VALUE);
    check(prog_mode, 1'b1);
    set_ir(prog_port_pkg::PROGRAM_CMD_INSTR);
    foreach (CMDS[i]) begin
      c = CMDS[i];
      if (c[7:0] == 8'h00 && c[14:12] < 3'h2) c[7:0] = 8'(next_rand());
      cmd_result = 15'(next_rand());
      dr(15, 144'(c));
      check(dout[14:0], cmd_result);
      check(cmd_word, c);
      execs = 0;
      u_prog_programmer.step(1'b0, 1'b0, v[0]);
      wait_clk(6);
      check(execs, 1);
    end
    // Poll the erase status until bit 9 of the result reads one.
    dout = '0;
    for (polls = 0; polls < 8 && dout[9] !== 1'b1; polls++) begin
      cmd_result = (polls > 2) ? 15'h0200 : 15'h0000;
      dr(15, 144'h3380);
    end
    check(polls, 4);
    set_ir(prog_port_pkg::PAGE_LOAD_INSTR);
    for (int i = 0; i < 17; i++) begin
      v[i*8+:8] = 8'(next_rand());
      if (i < 16) exp_q.push_back(v[i*8+:8]);
    end
    dr(136, v);
    check(load_ready, 1'b0);
    for (int n = 0; n < 200 && exp_q.size() > 0; n++) begin
      page_ready = (page_valid === 1'b1) && (next_rand() % 2 == 0);
      if (page_ready) check(page_data, exp_q.pop_front());
      wait_clk(1);
    end
    page_ready = 1'b0;
    check(exp_q.size(), 0);
    check(page_valid, 1'b0);
    set_ir(prog_port_pkg::PAGE_READ_INSTR);
    rd_q = '{8'(next_rand()), 8'(next_rand()), 8'(next_rand())};
    v = {rd_q[1], rd_q[0], 8'h00};
    dr(24, 144'(next_rand()));
    check(dout[23:0], v[23:0]);
    rd_q = {};
    key(prog_port_pkg::KEY_RESET);
    check(prog_mode, 1'b0);
    set_ir(prog_port_pkg::PAGE_LOAD_INSTR);
    dr(8, 144'h5a);
    wait_clk(4);
    check(page_valid, 1'b0);
    wrap_up();
  end
endmodule
